// ==== include/smrd_pkg.sv ====
package smrd_pkg;
  localparam logic [15:0] MR_RESET = 16'h0000;
  localparam logic [1:0] SEL_BURST = 2'h0;
  localparam logic [1:0] SEL_IO_TERM = 2'h1;
  localparam logic [1:0] SEL_REFRESH = 2'h2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_FLY = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam int MR0_PD_EXIT = 12;
  localparam int MR1_LOOP_DIS = 0;
  localparam int MR1_LEVEL = 7;
  localparam int MR1_STROBE_TERM = 11;
  localparam int MR1_OUT_OFF = 12;
  localparam int MR2_AUTO_SR = 6;
  localparam int MR2_TEMP_RANGE = 7;
  localparam logic [3:0] CWL_BASE = 4'h5;
  localparam logic [3:0] CL_BASE_LO = 4'h4;
  localparam logic [3:0] CL_BASE_HI = 4'hC;
  localparam logic [3:0] BURST_CLKS = 4'h4;
  localparam logic [3:0] CHOP_PULL_IN = 4'h2;
  localparam logic [3:0] DIV_OFF = 4'h0;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_7 = 4'h7;
  localparam logic [3:0] DIV_8 = 4'h8;
  localparam logic [3:0] DIV_12 = 4'hC;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_SELFREF = 2'h2
  } smrd_pwr_type;
endpackage

// ==== include/smrd_cmd_if.sv ====
interface smrd_cmd_if;
  logic mrs;
  logic [1:0] mrs_sel;
  logic [15:0] mrs_val;
  logic rd;
  logic wr;
  logic bc_fly_chop;
  logic sr_entry;
  logic cke;
  logic odt;
  modport src(output mrs, mrs_sel, mrs_val, rd, wr, bc_fly_chop, sr_entry, cke, odt);
  modport dst(input mrs, mrs_sel, mrs_val, rd, wr, bc_fly_chop, sr_entry, cke, odt);
endinterface

// ==== core/smrd_delay_line.sv ====
module smrd_delay_line #(
  parameter int unsigned DW = 1,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [DW-1:0] i_in,
  input wire logic [3:0] i_dly,
  output logic [DW-1:0] o_out
);
  logic [DW-1:0] sr_ff [DEPTH];

  generate
    if (DEPTH < 15) begin : g_bad_depth
      $error("smrd_delay_line needs DEPTH of 15 or more");
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) sr_ff[i] <= '0;
    end else begin
      sr_ff[0] <= i_in;
      for (int i = 1; i < DEPTH; i++) sr_ff[i] <= sr_ff[i-1];
    end
  end

  // Zero delay passes straight through so the caller's own register adds the only cycle
  always_comb begin
    if (i_dly == 4'h0) begin
      o_out = i_in;
    end else begin
      o_out = sr_ff[i_dly - 4'h1];
    end
  end
endmodule // smrd_delay_line

// ==== core/smrd_cmd_decode.sv ====
module smrd_cmd_decode (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [15:0] i_addr,
  input wire logic i_cke,
  input wire logic i_odt,
  smrd_cmd_if.src cmd
);
  localparam int PW = 25;
  logic [PW-1:0] s1_ff;
  logic [PW-1:0] s2_ff;
  logic cke_prev_ff;
  logic [3:0] strobes;

  // Pins are sampled twice before any decode reads them
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr, i_cke, i_odt};
      s2_ff <= s1_ff;
    end
  end

  assign strobes = s2_ff[24:21];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cke_prev_ff <= 1'b0;
      cmd.mrs <= 1'b0;
      cmd.mrs_sel <= 2'h0;
      cmd.mrs_val <= 16'h0000;
      cmd.rd <= 1'b0;
      cmd.wr <= 1'b0;
      cmd.bc_fly_chop <= 1'b0;
      cmd.sr_entry <= 1'b0;
      cmd.cke <= 1'b0;
      cmd.odt <= 1'b0;
    end else begin
      cke_prev_ff <= s2_ff[1];
      cmd.mrs <= (strobes == 4'h0) && !s2_ff[20] && cke_prev_ff;
      cmd.mrs_sel <= s2_ff[19:18];
      cmd.mrs_val <= s2_ff[17:2];
      cmd.rd <= (strobes == 4'h5) && cke_prev_ff;
      cmd.wr <= (strobes == 4'h4) && cke_prev_ff;
      // A12 low at the column command asks for a chop
      cmd.bc_fly_chop <= !s2_ff[14];
      cmd.sr_entry <= (strobes == 4'h1) && cke_prev_ff && !s2_ff[1];
      cmd.cke <= s2_ff[1];
      cmd.odt <= s2_ff[0];
    end
  end
endmodule // smrd_cmd_decode

// ==== core/smrd_top.sv ====
module smrd_top #(
  parameter int unsigned TRP_CYCLES = 11,
  parameter int unsigned WR_CODE0_CYCLES = 16,
  parameter int unsigned WR_CODE1_CYCLES = 5,
  parameter int unsigned DLY_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [15:0] i_addr,
  input wire logic i_cke,
  input wire logic i_odt,
  output logic o_int_read,
  output logic o_int_write,
  output logic o_rd_data_start,
  output logic o_wr_data_start,
  output logic o_wr_recovery_start,
  output logic o_wr_pull_in,
  output logic [3:0] o_cas_read_delay,
  output logic [3:0] o_additive_delay,
  output logic [3:0] o_cas_write_delay,
  output logic [4:0] o_read_latency,
  output logic [4:0] o_write_latency,
  output logic [4:0] o_write_recovery,
  output logic [5:0] o_dal_cycles,
  output logic [3:0] o_drive_div,
  output logic [3:0] o_rtt_nom_div,
  output logic [3:0] o_rtt_wr_div,
  output logic [3:0] o_rtt_now_div,
  output logic o_wr_level_en,
  output logic o_outputs_off,
  output logic o_extra_termination_strobe_en,
  output logic o_selfrefresh_temp_range,
  output logic o_automatic_selfrefresh,
  output logic [7:0] o_partial_array_retention,
  output logic o_dll_running,
  output logic o_pd_slow_exit,
  output logic o_cfg_reserved
);
  generate
    if (TRP_CYCLES < 1 || TRP_CYCLES > 31) begin : g_bad_trp
      $error("TRP_CYCLES must be 1 to 31");
    end
    if (WR_CODE0_CYCLES > 31 || WR_CODE1_CYCLES > 31) begin : g_bad_wr
      $error("write recovery codes must fit five bits");
    end
  endgenerate

  smrd_cmd_if cmd();

  smrd_cmd_decode u_decode (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_ras_n(i_ras_n),
    .i_cas_n(i_cas_n),
    .i_we_n(i_we_n),
    .i_ba(i_ba),
    .i_addr(i_addr),
    .i_cke(i_cke),
    .i_odt(i_odt),
    .cmd(cmd.src)
  );

  // Stored mode registers
  logic [15:0] burst_recovery_config_ff;
  logic [15:0] io_termination_latency_config_ff;
  logic [15:0] refresh_write_latency_config_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      burst_recovery_config_ff <= smrd_pkg::MR_RESET;
      io_termination_latency_config_ff <= smrd_pkg::MR_RESET;
      refresh_write_latency_config_ff <= smrd_pkg::MR_RESET;
    end else if (cmd.mrs) begin
      // Only the addressed register changes; the others keep their fields
      if (cmd.mrs_sel == smrd_pkg::SEL_BURST) begin
        burst_recovery_config_ff <= cmd.mrs_val;
      end else if (cmd.mrs_sel == smrd_pkg::SEL_IO_TERM) begin
        io_termination_latency_config_ff <= cmd.mrs_val;
      end else if (cmd.mrs_sel == smrd_pkg::SEL_REFRESH) begin
        refresh_write_latency_config_ff <= cmd.mrs_val;
      end
    end
  end

  logic [15:0] mr0;
  logic [15:0] mr1;
  logic [15:0] mr2;
  assign mr0 = burst_recovery_config_ff;
  assign mr1 = io_termination_latency_config_ff;
  assign mr2 = refresh_write_latency_config_ff;

  // Field decode
  logic [3:0] nxt_cas_read_delay;
  logic [3:0] nxt_additive_delay;
  logic [3:0] nxt_cas_write_delay;
  logic [4:0] nxt_write_recovery;
  logic [3:0] nxt_drive_div;
  logic [3:0] nxt_rtt_nom_div;
  logic [3:0] nxt_rtt_wr_div;
  logic [7:0] nxt_retention;
  logic cl_bad;
  logic al_bad;
  logic nom_bad;
  logic drv_bad;
  logic wrt_bad;
  logic cwl_bad;

  always_comb begin
    cl_bad = 1'b0;
    if (!mr0[2]) begin
      nxt_cas_read_delay = smrd_pkg::CL_BASE_LO + {1'b0, mr0[6:4]};
      cl_bad = (mr0[6:4] == 3'h0);
    end else begin
      nxt_cas_read_delay = smrd_pkg::CL_BASE_HI + {1'b0, mr0[6:4]};
      cl_bad = (mr0[6:4] > 3'h2);
    end
  end

  always_comb begin
    al_bad = 1'b0;
    case (mr1[4:3])
      2'h0: nxt_additive_delay = 4'h0;
      2'h1: nxt_additive_delay = nxt_cas_read_delay - 4'h1;
      2'h2: nxt_additive_delay = nxt_cas_read_delay - 4'h2;
      default: begin
        nxt_additive_delay = 4'h0;
        al_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    case (mr0[11:9])
      3'h0: nxt_write_recovery = 5'(WR_CODE0_CYCLES);
      3'h1: nxt_write_recovery = 5'(WR_CODE1_CYCLES);
      3'h2: nxt_write_recovery = 5'h06;
      3'h3: nxt_write_recovery = 5'h07;
      3'h4: nxt_write_recovery = 5'h08;
      3'h5: nxt_write_recovery = 5'h0A;
      3'h6: nxt_write_recovery = 5'h0C;
      default: nxt_write_recovery = 5'h0E;
    endcase
  end

  always_comb begin
    nom_bad = 1'b0;
    case ({mr1[9], mr1[6], mr1[2]})
      3'h0: nxt_rtt_nom_div = smrd_pkg::DIV_OFF;
      3'h1: nxt_rtt_nom_div = smrd_pkg::DIV_4;
      3'h2: nxt_rtt_nom_div = smrd_pkg::DIV_2;
      3'h3: nxt_rtt_nom_div = smrd_pkg::DIV_6;
      3'h4: nxt_rtt_nom_div = smrd_pkg::DIV_12;
      3'h5: nxt_rtt_nom_div = smrd_pkg::DIV_8;
      default: begin
        nxt_rtt_nom_div = smrd_pkg::DIV_OFF;
        nom_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    drv_bad = 1'b0;
    case ({mr1[5], mr1[1]})
      2'h0: nxt_drive_div = smrd_pkg::DIV_6;
      2'h1: nxt_drive_div = smrd_pkg::DIV_7;
      default: begin
        // Reserved codes keep the weaker legal driver rather than float
        nxt_drive_div = smrd_pkg::DIV_6;
        drv_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    wrt_bad = 1'b0;
    case (mr2[10:9])
      2'h0: nxt_rtt_wr_div = smrd_pkg::DIV_OFF;
      2'h1: nxt_rtt_wr_div = smrd_pkg::DIV_4;
      2'h2: nxt_rtt_wr_div = smrd_pkg::DIV_2;
      default: begin
        nxt_rtt_wr_div = smrd_pkg::DIV_OFF;
        wrt_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    cwl_bad = (mr2[5:4] == 2'h3);
    nxt_cas_write_delay = smrd_pkg::CWL_BASE + {1'b0, mr2[5:3]};
    if (cwl_bad) begin
      nxt_cas_write_delay = smrd_pkg::CWL_BASE;
    end
  end

  always_comb begin
    case (mr2[2:0])
      3'h0: nxt_retention = 8'hFF;
      3'h1: nxt_retention = 8'h0F;
      3'h2: nxt_retention = 8'h03;
      3'h3: nxt_retention = 8'h01;
      3'h4: nxt_retention = 8'hFC;
      3'h5: nxt_retention = 8'hF0;
      3'h6: nxt_retention = 8'hC0;
      default: nxt_retention = 8'h80;
    endcase
  end

  // Registered configuration view
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cas_read_delay <= 4'h0;
      o_additive_delay <= 4'h0;
      o_cas_write_delay <= 4'h0;
      o_read_latency <= 5'h00;
      o_write_latency <= 5'h00;
      o_write_recovery <= 5'h00;
      o_dal_cycles <= 6'h00;
      o_drive_div <= 4'h0;
      o_rtt_nom_div <= 4'h0;
      o_rtt_wr_div <= 4'h0;
      o_wr_level_en <= 1'b0;
      o_outputs_off <= 1'b0;
      o_extra_termination_strobe_en <= 1'b0;
      o_selfrefresh_temp_range <= 1'b0;
      o_automatic_selfrefresh <= 1'b0;
      o_partial_array_retention <= 8'h00;
      o_wr_pull_in <= 1'b0;
      o_cfg_reserved <= 1'b0;
    end else begin
      o_cas_read_delay <= nxt_cas_read_delay;
      o_additive_delay <= nxt_additive_delay;
      o_cas_write_delay <= nxt_cas_write_delay;
      o_read_latency <= {1'b0, nxt_additive_delay} + {1'b0, nxt_cas_read_delay};
      o_write_latency <= {1'b0, nxt_additive_delay} + {1'b0, nxt_cas_write_delay};
      o_write_recovery <= nxt_write_recovery;
      o_dal_cycles <= {1'b0, nxt_write_recovery} + 6'(TRP_CYCLES);
      o_drive_div <= nxt_drive_div;
      o_rtt_nom_div <= nxt_rtt_nom_div;
      o_rtt_wr_div <= nxt_rtt_wr_div;
      o_wr_level_en <= mr1[smrd_pkg::MR1_LEVEL];
      o_outputs_off <= mr1[smrd_pkg::MR1_OUT_OFF];
      o_extra_termination_strobe_en <= mr1[smrd_pkg::MR1_STROBE_TERM];
      o_selfrefresh_temp_range <= mr2[smrd_pkg::MR2_TEMP_RANGE];
      o_automatic_selfrefresh <= mr2[smrd_pkg::MR2_AUTO_SR];
      o_partial_array_retention <= nxt_retention;
      o_wr_pull_in <= (mr0[1:0] == smrd_pkg::BL_CHOP4);
      o_cfg_reserved <= cl_bad | al_bad | nom_bad | drv_bad | wrt_bad | cwl_bad |
        (mr0[1:0] == 2'h3);
    end
  end

  // Column commands: additive hold, then read or write delay
  logic [1:0] al_out;
  logic rd_start;
  logic wr_start;
  logic rec_start;
  logic [3:0] rec_dly;

  smrd_delay_line #(.DW(2), .DEPTH(DLY_DEPTH)) u_al_pipe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in({cmd.rd, cmd.wr}),
    .i_dly(nxt_additive_delay),
    .o_out(al_out)
  );

  smrd_delay_line #(.DW(1), .DEPTH(DLY_DEPTH)) u_rd_pipe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in(al_out[1]),
    .i_dly(nxt_cas_read_delay),
    .o_out(rd_start)
  );

  smrd_delay_line #(.DW(1), .DEPTH(DLY_DEPTH)) u_wr_pipe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in(al_out[0]),
    .i_dly(nxt_cas_write_delay),
    .o_out(wr_start)
  );

  // Fixed chop ends its data two clocks early; per-command chop keeps full length
  assign rec_dly = (mr0[1:0] == smrd_pkg::BL_CHOP4) ?
    smrd_pkg::BURST_CLKS - smrd_pkg::CHOP_PULL_IN : smrd_pkg::BURST_CLKS;

  smrd_delay_line #(.DW(1), .DEPTH(DLY_DEPTH)) u_rec_pipe (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in(wr_start),
    .i_dly(rec_dly),
    .o_out(rec_start)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_int_read <= 1'b0;
      o_int_write <= 1'b0;
      o_rd_data_start <= 1'b0;
      o_wr_data_start <= 1'b0;
      o_wr_recovery_start <= 1'b0;
    end else begin
      o_int_read <= al_out[1];
      o_int_write <= al_out[0];
      o_rd_data_start <= rd_start;
      o_wr_data_start <= wr_start;
      o_wr_recovery_start <= rec_start;
    end
  end

  // Termination in force: off while ODT is low, write value during write data, else nominal
  logic [3:0] wr_win_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_win_ff <= 4'h0;
    end else if (wr_start) begin
      wr_win_ff <= smrd_pkg::BURST_CLKS;
    end else if (wr_win_ff != 4'h0) begin
      wr_win_ff <= wr_win_ff - 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rtt_now_div <= 4'h0;
    end else if (!cmd.odt) begin
      o_rtt_now_div <= smrd_pkg::DIV_OFF;
    end else if ((wr_win_ff != 4'h0) && (nxt_rtt_wr_div != smrd_pkg::DIV_OFF) &&
                 !mr1[smrd_pkg::MR1_LEVEL]) begin
      // Write termination applies even when nominal is off; not during leveling
      o_rtt_now_div <= nxt_rtt_wr_div;
    end else begin
      o_rtt_now_div <= nxt_rtt_nom_div;
    end
  end

  // Power state and loop control
  smrd_pkg::smrd_pwr_type pwr_ff;
  logic pd_fast_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwr_ff <= smrd_pkg::PWR_ACTIVE;
    end else begin
      case (pwr_ff)
        smrd_pkg::PWR_ACTIVE: begin
          if (cmd.sr_entry) begin
            pwr_ff <= smrd_pkg::PWR_SELFREF;
          end else if (!cmd.cke) begin
            pwr_ff <= smrd_pkg::PWR_DOWN;
          end
        end
        smrd_pkg::PWR_DOWN: begin
          if (cmd.cke) begin
            pwr_ff <= smrd_pkg::PWR_ACTIVE;
          end
        end
        smrd_pkg::PWR_SELFREF: begin
          if (cmd.cke) begin
            pwr_ff <= smrd_pkg::PWR_ACTIVE;
          end
        end
        default: pwr_ff <= smrd_pkg::PWR_ACTIVE;
      endcase
    end
  end

  // Exit choice is taken at entry so a later mode set cannot change it mid power-down
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pd_fast_ff <= 1'b0;
    end else if (pwr_ff == smrd_pkg::PWR_ACTIVE) begin
      pd_fast_ff <= mr0[smrd_pkg::MR0_PD_EXIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dll_running <= 1'b0;
      o_pd_slow_exit <= 1'b0;
    end else begin
      o_dll_running <= !mr1[smrd_pkg::MR1_LOOP_DIS] &&
        (pwr_ff != smrd_pkg::PWR_SELFREF) &&
        !((pwr_ff == smrd_pkg::PWR_DOWN) && !pd_fast_ff);
      o_pd_slow_exit <= (pwr_ff == smrd_pkg::PWR_DOWN) && !pd_fast_ff;
    end
  end
endmodule // smrd_top

// ==== test/smrd_ctrl_model.sv ====
module smrd_ctrl_model #(
  parameter bit X16 = 1'b0,
  parameter int TXP = 3,
  parameter int TXPDLL = 10,
  parameter int TDLLK = 20,
  parameter int TWR_MIN = 5
) (
  input wire logic i_ref_clk,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [2:0] o_ba,
  output logic [15:0] o_addr,
  output logic o_cke
);
  logic loop_off = 1'b0;
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba = 3'h0;
    o_addr = 16'h0000;
    o_cke = 1'b1;
  end
  task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a);
    @(posedge i_ref_clk);
    #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = ba;
    o_addr = a;
    @(posedge i_ref_clk);
    #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    // Deselected lines must not keep showing the last command
    o_ba = ~o_ba;
    o_addr = ~o_addr;
  endtask
  task automatic mode_set(input logic [1:0] sel, input logic [15:0] v, output logic [15:0] m);
    m = v & ((sel == 2'h1) ? 16'h1AFF : (sel == 2'h2) ? 16'h06FF : 16'h1FFF);
    // Longest recovery code is always safe when the shortest may be too short
    if (sel == 2'h0 && TWR_MIN > 5) m[11:9] = 3'h0;
    if (sel == 2'h1) begin
      if (m[7] && !m[12] && (m[9] || !(m[6] || m[2]))) {m[9], m[2]} = 2'h1;
      if (X16) m[11] = 1'b0;
      if (m[0]) {m[9], m[6], m[2]} = 3'h0;
      loop_off = m[0];
    end
    if (sel == 2'h2 && loop_off) m[10:9] = 2'h0;
    cmd(4'h0, {1'b0, sel}, m);
    if (sel == 2'h0 && m[8]) repeat (TDLLK) @(posedge i_ref_clk);
  endtask
  task automatic pwr_enter(input bit sref);
    @(posedge i_ref_clk);
    #1;
    o_cke = 1'b0;
    if (sref) {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h1;
    @(posedge i_ref_clk);
    #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
  endtask
  task automatic pwr_exit(input bit slow);
    @(posedge i_ref_clk);
    #1;
    o_cke = 1'b1;
    repeat (slow ? TXPDLL : TXP) @(posedge i_ref_clk);
    #1;
  endtask
endmodule // smrd_ctrl_model

// ==== test/smrd_top_sva.sv ====
module smrd_top_sva #(
  parameter int unsigned TRP_CYCLES = 11
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [15:0] i_addr,
  input wire logic i_cke,
  input wire logic o_int_read,
  input wire logic o_int_write,
  input wire logic o_rd_data_start,
  input wire logic o_wr_data_start,
  input wire logic o_wr_recovery_start,
  input wire logic o_wr_pull_in,
  input wire logic [3:0] o_cas_read_delay,
  input wire logic [3:0] o_additive_delay,
  input wire logic [4:0] o_read_latency,
  input wire logic [4:0] o_write_recovery,
  input wire logic [5:0] o_dal_cycles,
  input wire logic o_wr_level_en,
  input wire logic o_outputs_off,
  input wire logic o_extra_termination_strobe_en,
  input wire logic o_selfrefresh_temp_range,
  input wire logic o_automatic_selfrefresh
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_mrs(logic [1:0] sel);
    !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n && i_ba == {1'b0, sel} && i_cke && $past(i_cke);
  endsequence
  sequence s_rd;
    !i_cs_n && i_ras_n && !i_cas_n && i_we_n && i_cke;
  endsequence
  sequence s_wr;
    !i_cs_n && i_ras_n && !i_cas_n && !i_we_n && i_cke;
  endsequence
  a_chop_level: assert property (s_mrs(2'h0) |-> ##5
    o_wr_pull_in == ($past(i_addr[1:0], 5) == 2'h2)) else $error("pull-in wrong");
  a_mr1_bits: assert property (s_mrs(2'h1) |-> ##5
    {o_outputs_off, o_extra_termination_strobe_en, o_wr_level_en} ==
    {$past(i_addr[12], 5), $past(i_addr[11], 5), $past(i_addr[7], 5)}) else $error("mr1 bits");
  a_mr2_bits: assert property (s_mrs(2'h2) |-> ##5
    {o_selfrefresh_temp_range, o_automatic_selfrefresh} == $past(i_addr[7:6], 5))
    else $error("self-refresh bits wrong");
  // Guards skip the settling edges just after reset
  a_read_sum: assert property ($stable(o_additive_delay) && $stable(o_cas_read_delay) |->
    o_read_latency == o_additive_delay + o_cas_read_delay) else $error("read latency sum");
  a_dal_sum: assert property (!$past(i_rst, 2) && $stable(o_write_recovery) |->
    o_dal_cycles == o_write_recovery + TRP_CYCLES) else $error("dal sum wrong");
  a_int_read: assert property (s_rd ##0 (o_additive_delay == 4'h0) |-> ##4 o_int_read)
    else $error("internal read late");
  a_int_write: assert property (s_wr ##0 (o_additive_delay == 4'h0) |-> ##4 o_int_write)
    else $error("internal write late");
  a_rd_start: assert property (o_int_read && o_cas_read_delay == 4'h6 |-> ##6 o_rd_data_start)
    else $error("read data start late");
  a_rec_fixed: assert property (o_wr_data_start && !o_wr_pull_in |-> ##4 o_wr_recovery_start)
    else $error("recovery start not at 4");
  a_rec_chop: assert property (o_wr_data_start && o_wr_pull_in |-> ##2 o_wr_recovery_start)
    else $error("recovery start not at 2");
endmodule // smrd_top_sva
bind smrd_top smrd_top_sva #(.TRP_CYCLES(TRP_CYCLES)) smrd_top_sva_inst (.*);

// ==== test/smrd_top_tb.sv ====
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module smrd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TRP = 11;
  localparam logic [4:0] WR_LUT [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
  localparam logic [3:0] NOM_LUT [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8, 4'h0, 4'h0};
  localparam logic [7:0] PA_LUT [8] = '{8'hFF, 8'h0F, 8'h03, 8'h01, 8'hFC, 8'hF0, 8'hC0, 8'h80};
  typedef struct {string nm; logic [7:0] v;} smrd_note_type;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_odt = 1'b0;
  wire logic i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke;
  wire logic [2:0] i_ba;
  wire logic [15:0] i_addr;
  logic o_int_read, o_int_write, o_rd_data_start, o_wr_data_start, o_wr_recovery_start;
  logic o_wr_pull_in, o_wr_level_en, o_outputs_off, o_extra_termination_strobe_en;
  logic o_selfrefresh_temp_range, o_automatic_selfrefresh, o_dll_running, o_pd_slow_exit;
  logic o_cfg_reserved;
  logic [3:0] o_cas_read_delay, o_additive_delay, o_cas_write_delay;
  logic [3:0] o_drive_div, o_rtt_nom_div, o_rtt_wr_div, o_rtt_now_div;
  logic [4:0] o_read_latency, o_write_latency, o_write_recovery;
  logic [5:0] o_dal_cycles;
  logic [7:0] o_partial_array_retention;
  smrd_note_type notes[$];
  int unsigned rd_q[$], rec_q[$];
  int unsigned cyc = 0;
  int unsigned n_fail = 0;
  int unsigned samples_checked = 0;
  event probe;
  always #10 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  smrd_top smrd_top_inst (.*);
  smrd_ctrl_model smrd_ctrl_model_inst (.i_ref_clk(i_ref_clk), .o_cs_n(i_cs_n),
    .o_ras_n(i_ras_n), .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_ba(i_ba), .o_addr(i_addr),
    .o_cke(i_cke));
  function automatic logic [7:0] fld(input string nm);
    case (nm)
      "drive": return {4'h0, o_drive_div};
      "nom": return {4'h0, o_rtt_nom_div};
      "al": return {4'h0, o_additive_delay};
      "cl": return {4'h0, o_cas_read_delay};
      "rl": return {3'h0, o_read_latency};
      "cwl": return {4'h0, o_cas_write_delay};
      "wl": return {3'h0, o_write_latency};
      "rwr": return {4'h0, o_rtt_wr_div};
      "partial_array_retention": return o_partial_array_retention;
      "wr": return {3'h0, o_write_recovery};
      "dal": return {2'h0, o_dal_cycles};
      "res": return {7'h0, o_cfg_reserved};
      "now": return {4'h0, o_rtt_now_div};
      "dll": return {7'h0, o_dll_running};
      default: return {7'h0, o_pd_slow_exit};
    endcase
  endfunction
  task automatic note(input string nm, input logic [7:0] v);
    notes.push_back('{nm, v});
  endtask
  task automatic expect_cfg(input logic [15:0] m0, m1, m2, output int unsigned al, wl);
    logic [2:0] nc;
    logic [3:0] a, c;
    nc = {m1[9], m1[6], m1[2]};
    a = (m1[4:3] == 2'h0) ? 4'h0 : 4'h6 - {2'h0, m1[4:3]};
    c = (m2[5:3] > 3'h5) ? 4'h5 : 4'h5 + {1'b0, m2[5:3]};
    al = a;
    wl = a + c;
    note("drive", (!m1[5] && m1[1]) ? 8'h07 : 8'h06);
    note("nom", {4'h0, NOM_LUT[nc]});
    note("al", {4'h0, a});
    if (m0 !== 16'h0000) note("cl", 8'h06);
    if (m0 !== 16'h0000) note("rl", {4'h0, a} + 8'h06);
    note("cwl", {4'h0, c});
    note("wl", {4'h0, a + c});
    note("rwr", (m2[10:9] == 2'h1) ? 8'h04 : (m2[10:9] == 2'h2) ? 8'h02 : 8'h00);
    note("partial_array_retention", PA_LUT[m2[2:0]]);
    note("wr", {3'h0, WR_LUT[m0[11:9]]});
    note("dal", 8'({3'h0, WR_LUT[m0[11:9]]} + TRP));
    note("now", i_odt ? {4'h0, NOM_LUT[nc]} : 8'h00);
    note("dll", {7'h0, !m1[0]});
    // Reset leaves a reserved read delay code, so the flag is judged only once set legally
    if (m0 !== 16'h0000) note("res", {7'h0, m1[5] | (nc > 3'h5) | (m2[5:3] > 3'h5) |
      (m2[10:9] == 2'h3)});
    -> probe;
  endtask
  always @(probe) begin
    while (notes.size() > 0) begin
      smrd_note_type n;
      n = notes.pop_front();
      `CHK(n.nm, n.v, fld(n.nm))
    end
  end
  always @(negedge i_ref_clk) begin
    int unsigned e;
    if (o_rd_data_start === 1'b1) begin
      e = rd_q.pop_front();
      `CHK("rd start", e, cyc)
    end
    if (o_wr_recovery_start === 1'b1) begin
      e = rec_q.pop_front();
      `CHK("wr recovery", e, cyc)
    end
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [15:0] r0, r1, r2, m0, m1, m2;
    int unsigned al, wl;
    r0 = $urandom(37);
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    repeat (2) settle();
    expect_cfg(16'h0000, 16'h0000, 16'h0000, al, wl);
    for (int i = 0; i < 16; i++) begin
      r0 = $urandom();
      r1 = $urandom();
      r2 = $urandom();
      if (r1[4:3] == 2'h3) r1[4] = 1'b0;
      r0 = {3'h0, r0[12:9], 2'h0, 3'h2, r0[3], 1'b0, r0[1] & ~r0[0], r0[0]};
      i_odt = r2[15];
      smrd_ctrl_model_inst.mode_set(2'h0, r0, m0);
      smrd_ctrl_model_inst.mode_set(2'h1, r1, m1);
      smrd_ctrl_model_inst.mode_set(2'h2, r2, m2);
      settle();
      expect_cfg(m0, m1, m2, al, wl);
      smrd_ctrl_model_inst.cmd(4'h4, 3'h0, 16'h0000);
      rec_q.push_back(cyc + 3 + wl + ((m0[1:0] == 2'h2) ? 2 : 4));
      smrd_ctrl_model_inst.cmd(4'h5, 3'h0, 16'h0000);
      rd_q.push_back(cyc + 3 + al + 6);
      repeat (30) @(posedge i_ref_clk);
      smrd_ctrl_model_inst.pwr_enter(i[0]);
      settle();
      note("dll", {7'h0, !m1[0] && !i[0] && m0[12]});
      if (!i[0]) note("pds", {7'h0, !m0[12]});
      -> probe;
      smrd_ctrl_model_inst.pwr_exit(!m0[12]);
      settle();
      note("dll", {7'h0, !m1[0]});
      -> probe;
    end
    repeat (40) @(posedge i_ref_clk);
    `CHK("pending strobes", 0, rd_q.size() + rec_q.size())
    give_verdict();
  end
endmodule // smrd_top_tb
